// >>> core/pbs_sequencer.sv
// Operation
// [RULE1] A low shutdown request in normal operation releases the power enable at once; the code releases it only once the low has qualified (see [RULE10]).
// [RULE2] After a shutdown request release, the pushbutton is ignored for 256ms.
// [RULE3] A parameter selects high-true or low-true enable; nothing else differs.
// [RULE4] A sequence starts only after the pushbutton is held low for the full hold time.
// [RULE5] Without extensions both hold times are 32ms.
// [RULE6] The turn-on extension adds 1ms plus a programmable time to the 32ms hold.
// [RULE7] The turn-off extension adds a programmable time, independent of turn-on.
// [RULE8] The enable is released at most 1024ms after a valid turn-off begins.
// [RULE9] The host should drive the shutdown request low before the 1024ms expires.
// [RULE10] A shutdown request low counts only if it lasts at least 30us.
// [RULE11] The enable releases about 30us after a qualifying shutdown request low.
// [RULE12] A 512ms blanking starts at enable; if the request is not high at its end, enable drops.
// [RULE13] A completed turn-off hold asserts the active-low alert to the host.
// [RULE14] The pushbutton returning high before the hold ends restarts the debounce.
// [RULE15] After each on or off action the release is debounced for 32ms.
// [RULE16] All intervals come from one time-base tick counter; extensions are parameters.
// [RULE17] After reset enable and alert are deasserted and a press is awaited.
`timescale 1ns/1ns
module pbs_sequencer
  import pbs_pkg::*;
#(
  parameter bit          EN_HIGH_TRUE = 1'b1,   // 1: enable high when on
  parameter bit          ON_EXT_EN    = 1'b0,   // Turn-on extension fitted
  parameter bit          OFF_EXT_EN   = 1'b0,   // Turn-off extension fitted
  parameter int unsigned ON_EXT_TICKS = 0,      // Extra turn-on ticks
  parameter int unsigned OFF_EXT_TICKS= 0,      // Extra turn-off ticks
  parameter int unsigned TICK_CYCLES  = pbs_pkg::TICK_CYC,
  parameter int unsigned MS_TICKS     = pbs_pkg::TICKS_PER_MS, // Ticks in one millisecond
  parameter int unsigned KILL_LOW_TICKS = pbs_pkg::KILL_TICKS  // Ticks a request low must last
) (
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               sys_rst_i,
  // Pins
  input  wire logic               pushbutton_n_i,
  input  wire logic               shutdown_req_n_i,
  output logic                    power_en_o,      // Open-drain level, polarity per variant
  output logic                    power_en_oe_n_o, // Low while the pin is pulled
  output logic                    alert_n_o,
  // Status
  output pbs_pkg::pbs_status_t    status_o
);
  import pbs_pkg::*;

  // Millisecond figures scale with MS_TICKS so a fast time base keeps every ratio
  localparam int unsigned DEB_T     = DEBOUNCE_MS * MS_TICKS;
  localparam int unsigned BLK_T     = BLANK_MS * MS_TICKS;
  localparam int unsigned OFFD_T    = OFF_DELAY_MS * MS_TICKS;
  localparam int unsigned LOCK_T    = LOCKOUT_MS * MS_TICKS;
  localparam int unsigned ON_TICKS  = DEB_T + (ON_EXT_EN ? EXT_BASE_MS * MS_TICKS + ON_EXT_TICKS : 0);
  localparam int unsigned OFF_TICKS = DEB_T + (OFF_EXT_EN ? OFF_EXT_TICKS : 0);

  initial begin
    if (TICK_CYCLES < 1 || TICK_CYCLES > 65536) $error("TICK_CYCLES out of range");
    if (MS_TICKS < 1) $error("MS_TICKS must be at least one");
    if (KILL_LOW_TICKS < 1 || KILL_LOW_TICKS > 256) $error("KILL_LOW_TICKS out of range");
    if (ON_TICKS >= 32'h00ff_ffff || OFF_TICKS >= 32'h00ff_ffff) $error("Extension too long");
    if (OFFD_T >= 32'h00ff_ffff) $error("Forced-off delay too long");
  end

  // ==========================================================================
  // Input synchronisers
  // ==========================================================================
  // Three stages; a change counts only when stages two and three agree
  logic [2:0] pb_sync_r, pb_sync_nxt, kl_sync_r, kl_sync_nxt;
  logic       pb_lvl_r, pb_lvl_nxt, kl_lvl_r, kl_lvl_nxt;

  always_comb begin
    pb_sync_nxt = {pb_sync_r[1:0], pushbutton_n_i};
    kl_sync_nxt = {kl_sync_r[1:0], shutdown_req_n_i};
    pb_lvl_nxt  = (pb_sync_r[2] == pb_sync_r[1]) ? pb_sync_r[2] : pb_lvl_r;
    kl_lvl_nxt  = (kl_sync_r[2] == kl_sync_r[1]) ? kl_sync_r[2] : kl_lvl_r;
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pb_sync_r <= 3'h7;
      kl_sync_r <= 3'h7;
      pb_lvl_r  <= 1'b1;
      kl_lvl_r  <= 1'b1;
    end else begin
      pb_sync_r <= pb_sync_nxt;
      kl_sync_r <= kl_sync_nxt;
      pb_lvl_r  <= pb_lvl_nxt;
      kl_lvl_r  <= kl_lvl_nxt;
    end
  end

  // ==========================================================================
  // Time base
  // ==========================================================================
  // One tick pulse feeds every interval counter
  logic [15:0] div_r, div_nxt;
  logic        tick;

  always_comb begin
    tick    = (div_r == 16'(TICK_CYCLES - 1));
    div_nxt = tick ? 16'h0000 : div_r + 16'h0001;
  end // see [RULE16]

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) div_r <= 16'h0000;
    else           div_r <= div_nxt;
  end

  // ==========================================================================
  // Shutdown request qualifier
  // ==========================================================================
  // Short lows are filtered so glitches on a monitor divider do not kill power
  logic [7:0] kl_cnt_r, kl_cnt_nxt;
  logic       kill_q_r, kill_q_nxt;

  always_comb begin
    kl_cnt_nxt = kl_cnt_r;
    kill_q_nxt = kill_q_r;
    if (kl_lvl_r) begin
      kl_cnt_nxt = 8'h00;
      kill_q_nxt = 1'b0;
    end else if (tick && !kill_q_r) begin
      if (kl_cnt_r == 8'(KILL_LOW_TICKS - 1)) kill_q_nxt = 1'b1; // see [RULE10]
      else                                kl_cnt_nxt = kl_cnt_r + 8'h01;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      kl_cnt_r <= 8'h00;
      kill_q_r <= 1'b0;
    end else begin
      kl_cnt_r <= kl_cnt_nxt;
      kill_q_r <= kill_q_nxt;
    end
  end

  // ==========================================================================
  // Sequencer
  // ==========================================================================
  pbs_state_t  st_r, st_nxt;
  logic [23:0] tmr_r, tmr_nxt;
  logic [23:0] aux_r, aux_nxt;     // Forced-off counter, counts down only in the alert state
  logic        on_r, on_nxt;
  logic        alert_r, alert_nxt;
  logic        done;

  assign done = tick && (tmr_r == 24'h00_0001);

  always_comb begin
    st_nxt    = st_r;
    tmr_nxt   = (tick && tmr_r != 24'h00_0000) ? tmr_r - 24'h00_0001 : tmr_r;
    aux_nxt   = aux_r;
    on_nxt    = on_r;
    alert_nxt = alert_r;
    case (st_r)
      PBS_IDLE: begin
        if (!pb_lvl_r) begin
          st_nxt  = PBS_ON_HOLD;
          tmr_nxt = 24'(ON_TICKS); // see [RULE5] see [RULE6]
        end
      end
      PBS_ON_HOLD: begin
        if (pb_lvl_r) st_nxt = PBS_IDLE; // see [RULE14]
        else if (done) begin
          st_nxt  = PBS_BLANK; // see [RULE4]
          on_nxt  = 1'b1;
          tmr_nxt = 24'(BLK_T);
        end
      end
      PBS_BLANK: begin
        // Button and request are not looked at until blanking ends
        if (done) begin
          if (!kl_lvl_r) begin
            on_nxt  = 1'b0; // see [RULE12]
            st_nxt  = PBS_REL_OFF;
            tmr_nxt = 24'(DEB_T);
          end else begin
            st_nxt  = PBS_REL_ON;
            tmr_nxt = 24'(DEB_T);
          end
        end
      end
      PBS_REL_ON, PBS_RUN: begin
        if (kill_q_r) begin
          on_nxt  = 1'b0; // see [RULE1] see [RULE11]
          st_nxt  = PBS_LOCKOUT;
          tmr_nxt = 24'(LOCK_T);
        end else if (st_r == PBS_REL_ON) begin
          if (!pb_lvl_r) tmr_nxt = 24'(DEB_T); // see [RULE15]
          else if (done) st_nxt = PBS_RUN;
        end else if (!pb_lvl_r) begin
          st_nxt  = PBS_OFF_HOLD;
          tmr_nxt = 24'(OFF_TICKS); // see [RULE7]
        end
      end
      PBS_OFF_HOLD: begin
        if (kill_q_r) begin
          on_nxt  = 1'b0;
          st_nxt  = PBS_LOCKOUT;
          tmr_nxt = 24'(LOCK_T);
        end else if (pb_lvl_r) st_nxt = PBS_RUN; // see [RULE14]
        else if (done) begin
          alert_nxt = 1'b1; // see [RULE13]
          st_nxt    = PBS_ALERT;
          aux_nxt   = 24'(OFFD_T);
        end
      end
      PBS_ALERT: begin
        // Host normally finishes housekeeping first; the forced delay is a backstop
        if (tick && aux_r != 24'h00_0000) aux_nxt = aux_r - 24'h00_0001;
        if (kill_q_r) begin
          on_nxt    = 1'b0;
          alert_nxt = 1'b0;
          st_nxt    = PBS_LOCKOUT;
          tmr_nxt   = 24'(LOCK_T);
        end else if (tick && aux_r == 24'h00_0001) begin
          on_nxt    = 1'b0; // see [RULE8]
          alert_nxt = 1'b0;
          st_nxt    = PBS_REL_OFF;
          tmr_nxt   = 24'(DEB_T);
        end
      end
      PBS_LOCKOUT: begin
        if (done) begin
          st_nxt  = PBS_REL_OFF; // see [RULE2]
          tmr_nxt = 24'(DEB_T);
        end
      end
      PBS_REL_OFF: begin
        if (!pb_lvl_r) tmr_nxt = 24'(DEB_T); // see [RULE15]
        else if (done) st_nxt = PBS_IDLE;
      end
      default: st_nxt = PBS_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_r    <= PBS_IDLE; // see [RULE17]
      tmr_r   <= 24'h00_0000;
      aux_r   <= 24'h00_0000;
      on_r    <= ON_RST;
      alert_r <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      tmr_r   <= tmr_nxt;
      aux_r   <= aux_nxt;
      on_r    <= on_nxt;
      alert_r <= alert_nxt;
    end
  end

  // ==========================================================================
  // Output registers
  // ==========================================================================
  // Registered from the next-state values so every pin comes straight from a flip-flop with no added cycle
  logic        en_r, oe_n_r, alert_n_r;
  pbs_status_t stat_r;

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      en_r      <= ~EN_HIGH_TRUE;
      oe_n_r    <= EN_HIGH_TRUE ? 1'b0 : 1'b1;
      alert_n_r <= 1'b1;
      stat_r    <= '0;
    end else begin
      en_r      <= EN_HIGH_TRUE ? on_nxt : ~on_nxt; // see [RULE3]
      oe_n_r    <= EN_HIGH_TRUE ? on_nxt : ~on_nxt; // Pulls low when enable level is low
      alert_n_r <= ~alert_nxt;
      stat_r    <= '{powered: on_nxt, alerting: alert_nxt, locked: (st_nxt == PBS_LOCKOUT)};
    end
  end

  assign power_en_o      = en_r;
  assign power_en_oe_n_o = oe_n_r;
  assign alert_n_o       = alert_n_r;
  assign status_o        = stat_r;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  sequence s_kill_seen;
    kill_q_r && (st_r == PBS_RUN || st_r == PBS_ALERT || st_r == PBS_OFF_HOLD);
  endsequence

  a_kill_drops_en: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see [RULE1]
    s_kill_seen |=> !on_r ##1 (status_o.powered == 1'b0))
    else $error("Enable not released after shutdown request");

  a_lockout_ignores_pb: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see [RULE2]
    (st_r == PBS_LOCKOUT) |=> (st_r == PBS_LOCKOUT || st_r == PBS_REL_OFF))
    else $error("Pushbutton acted during lockout");

  a_polarity_map: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see [RULE3]
    power_en_o == (EN_HIGH_TRUE ? status_o.powered : !status_o.powered))
    else $error("Enable polarity wrong");

  a_hold_restart: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see [RULE14]
    (st_r == PBS_ON_HOLD && pb_lvl_r) |=> (st_r == PBS_IDLE && !on_r))
    else $error("Hold not restarted on release");

  a_on_needs_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see [RULE4]
    $rose(on_r) |-> $past(st_r) == PBS_ON_HOLD)
    else $error("Enable rose without a hold");

  a_kill_filter: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see [RULE10]
    $rose(kill_q_r) |-> !$past(kl_lvl_r) && $past(kl_cnt_r) == 8'(KILL_LOW_TICKS - 1))
    else $error("Short request low qualified");

  a_alert_on_done: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see [RULE13]
    $rose(alert_r) |-> ##1 !alert_n_o)
    else $error("Alert not driven");

  a_forced_off: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see [RULE8]
    (st_r == PBS_ALERT) |-> aux_r <= 24'(OFFD_T))
    else $error("Forced-off counter out of range");

  a_blank_abort: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see [RULE12]
    (st_r == PBS_BLANK && done && !kl_lvl_r) |=> !on_r)
    else $error("Blanking end did not abort power on");
endmodule : pbs_sequencer

// >>> core/pbs_pkg.sv
package pbs_pkg;
  // ==========================================================================
  // Clock rate
  // ==========================================================================
  localparam int unsigned CLK_HZ         = 250_000_000;

  // ==========================================================================
  // Interval figures
  // ==========================================================================
  localparam int unsigned TICK_US        = 1;      // Time-base tick, microseconds
  localparam int unsigned DEBOUNCE_MS    = 32;     // Base hold and release debounce
  localparam int unsigned EXT_BASE_MS    = 1;      // Fixed part of the turn-on extension
  localparam int unsigned BLANK_MS       = 512;    // Shutdown request blanking after power on
  localparam int unsigned OFF_DELAY_MS   = 1024;   // Forced-off delay after alert
  localparam int unsigned LOCKOUT_MS     = 256;    // Pushbutton lockout after shutdown request release
  localparam int unsigned KILL_MIN_US    = 30;     // Least qualifying low on shutdown request

  // ==========================================================================
  // Derived counts
  // ==========================================================================
  localparam int unsigned TICK_CYC       = (CLK_HZ / 1_000_000) * TICK_US;
  localparam int unsigned TICKS_PER_MS   = 1000 / TICK_US;
  localparam int unsigned DEBOUNCE_TICKS = DEBOUNCE_MS * TICKS_PER_MS;
  localparam int unsigned EXT_BASE_TICKS = EXT_BASE_MS * TICKS_PER_MS;
  localparam int unsigned BLANK_TICKS    = BLANK_MS * TICKS_PER_MS;
  localparam int unsigned OFF_DLY_TICKS  = OFF_DELAY_MS * TICKS_PER_MS;
  localparam int unsigned LOCKOUT_TICKS  = LOCKOUT_MS * TICKS_PER_MS;
  localparam int unsigned KILL_TICKS     = (KILL_MIN_US + TICK_US - 1) / TICK_US;

  // ==========================================================================
  // Reset values and types
  // ==========================================================================
  localparam logic        ON_RST         = 1'b0;

  typedef enum logic [3:0] {
    PBS_IDLE, PBS_ON_HOLD, PBS_BLANK, PBS_REL_ON, PBS_RUN,
    PBS_OFF_HOLD, PBS_ALERT, PBS_LOCKOUT, PBS_REL_OFF
  } pbs_state_t;

  // Status outputs grouped together
  typedef struct packed {
    logic powered;
    logic alerting;
    logic locked;
  } pbs_status_t;
endpackage : pbs_pkg

// >>> verif/pbs_partner_model.sv
`timescale 1ns/1ns
module pbs_partner_model
  import pbs_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  // Bench controls
  input  wire logic       press_i,
  input  wire logic       kill_i,
  input  wire logic [1:0] mode_i,       // 0 prompt, 1 never raises, 2 ignores alert
  // Device side
  input  wire logic       powered_i,
  input  wire logic       alert_n_i,
  output logic            pushbutton_n_o,
  output logic            shutdown_req_n_o
);
  int up_cnt;
  int alert_cnt;

  // ==========================================================================
  // Switch and host
  // ==========================================================================
  // Pull-up holds the button line high while the contact is open
  assign pushbutton_n_o = ~press_i;

  // Host counts its powered time and its alerted time
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i || !powered_i) begin
      up_cnt    <= 0;
      alert_cnt <= 0;
    end else begin
      up_cnt    <= (up_cnt < 5000) ? up_cnt + 1 : up_cnt;
      alert_cnt <= !alert_n_i ? alert_cnt + 1 : 0;
    end
  end

  // An unpowered host cannot hold the request high, so it reads low then
  assign shutdown_req_n_o = (up_cnt >= 1000) && (mode_i != 2'h1) && !kill_i &&
                            !((mode_i == 2'h0) && (alert_cnt >= 2000));
endmodule : pbs_partner_model

// >>> verif/tb.sv
`timescale 1ns/1ns
module tb;
  import pbs_pkg::*;
  // One tick per clock and a short millisecond keep the run small
  localparam int MS   = 8;
  localparam int ON   = DEBOUNCE_MS * MS;
  localparam int DEB  = DEBOUNCE_MS * MS;
  localparam int BLK  = BLANK_MS * MS;
  localparam int OFFD = OFF_DELAY_MS * MS;
  localparam int LOCK = LOCKOUT_MS * MS;

  logic        clk_i, sys_rst_i, press, kill;
  logic [1:0]  mode;
  logic        pb_n, req_n, en_pin, en_low_pin;
  logic        en, oe_n, alert_n, en_l, oe_n_l, en_x;
  pbs_status_t status;
  logic [31:0] seed = 32'hefbe;
  int          model_on, model_alert, n_errors, comparisons;

  // ==========================================================================
  // Instances
  // ==========================================================================
  pbs_sequencer #(.EN_HIGH_TRUE(1'b1), .TICK_CYCLES(1), .MS_TICKS(MS)) dut_u (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .pushbutton_n_i(pb_n), .shutdown_req_n_i(req_n),
    .power_en_o(en), .power_en_oe_n_o(oe_n), .alert_n_o(alert_n), .status_o(status));
  pbs_sequencer #(.EN_HIGH_TRUE(1'b0), .TICK_CYCLES(1), .MS_TICKS(MS)) dut_low_u (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .pushbutton_n_i(pb_n), .shutdown_req_n_i(req_n),
    .power_en_o(en_l), .power_en_oe_n_o(oe_n_l), .alert_n_o(), .status_o());
  // Turn-on extension fitted: 1ms plus 40 ticks beyond the base hold
  pbs_sequencer #(.EN_HIGH_TRUE(1'b1), .ON_EXT_EN(1'b1), .ON_EXT_TICKS(40), .TICK_CYCLES(1),
                  .MS_TICKS(MS)) dut_ext_u (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .pushbutton_n_i(pb_n), .shutdown_req_n_i(req_n),
    .power_en_o(en_x), .power_en_oe_n_o(), .alert_n_o(), .status_o());
  pbs_partner_model partner_u (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .press_i(press), .kill_i(kill), .mode_i(mode),
    .powered_i(en_pin), .alert_n_i(alert_n), .pushbutton_n_o(pb_n), .shutdown_req_n_o(req_n));

  // Enable pins are open drain with pull-ups
  assign en_pin     = oe_n ? 1'b1 : 1'b0;
  assign en_low_pin = oe_n_l ? 1'b1 : 1'b0;

  // ==========================================================================
  // Tasks
  // ==========================================================================
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick

  task automatic check_en(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: enable got %h expected %h", $time, got, exp);
    end
  endtask : check_en

  task automatic check_alert(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: alert got %h expected %h", $time, got, exp);
    end
  endtask : check_alert

  task automatic results;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results

  // Hold the button through turn-on, then watch blanking end; exp_keep says if power survives
  task automatic power_on(input int exp_keep);
    press = 1'b1;
    tick(ON - 20);
    check_en(en_pin, model_on[0]);
    tick(40);
    model_on = 1;
    check_en(en_pin, model_on[0]);
    check_en(status.powered, model_on[0]);
    check_en(en_x, 1'b0);
    tick(60);
    check_en(en_x, 1'b1);
    press = 1'b0;
    tick(BLK - 160);
    check_en(en_pin, model_on[0]);
    tick(200);
    model_on = exp_keep;
    check_en(en_pin, model_on[0]);
    tick(DEB + 100);
  endtask : power_on

  // ==========================================================================
  // Clock, polarity monitor and watchdog
  // ==========================================================================
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // The low-true variant mirrors the high-true one on every cycle
  always @(negedge clk_i) begin
    if (!sys_rst_i) begin
      check_en(en_low_pin, ~en_pin);
      check_en(en, en_pin);
    end
  end

  // About twice the length of the whole sequence
  initial begin
    tick(60_000);
    n_errors++;
    $display("Error at %0t: watchdog expired", $time);
    results();
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    sys_rst_i = 1'b1;
    press = 1'b0;
    kill = 1'b0;
    mode = 2'h0;
    model_on = 0;
    model_alert = 1;
    tick(4);
    sys_rst_i = 1'b0;
    tick(10);
    check_en(en_pin, model_on[0]);
    check_alert(alert_n, model_alert[0]);
    // Bouncy presses, each shorter than the hold, must never turn on
    repeat (3) begin
      seed = lfsr_next(seed);
      press = 1'b1;
      tick(20 + int'(seed % 32'd200));
      press = 1'b0;
      tick(50);
    end
    check_en(en_pin, model_on[0]);
    power_on(1);
    // Short request glitch is ignored
    seed = lfsr_next(seed);
    kill = 1'b1;
    tick(1 + int'(seed % 32'd20));
    kill = 1'b0;
    tick(100);
    check_en(en_pin, model_on[0]);
    // Host ignores the alert: forced release after the off delay
    mode = 2'h2;
    press = 1'b1;
    tick(DEB - 20);
    check_alert(alert_n, model_alert[0]);
    tick(40);
    model_alert = 0;
    check_alert(alert_n, model_alert[0]);
    check_alert(status.alerting, 1'b1);
    press = 1'b0;
    tick(OFFD - 100);
    check_en(en_pin, model_on[0]);
    tick(200);
    model_on = 0;
    model_alert = 1;
    check_en(en_pin, model_on[0]);
    check_alert(alert_n, model_alert[0]);
    tick(DEB + 100);
    mode = 2'h0;
    power_on(1);
    // Direct request in normal operation, then lockout
    kill = 1'b1;
    tick(20);
    check_en(en_pin, model_on[0]);
    tick(40);
    model_on = 0;
    check_en(en_pin, model_on[0]);
    kill = 1'b0;
    press = 1'b1;
    tick(ON + 500);
    check_en(en_pin, model_on[0]);
    check_en(status.locked, 1'b1);
    press = 1'b0;
    tick(LOCK + DEB + 200 - ON - 500);
    // Host never raises the request: power-on aborts at blanking end
    mode = 2'h1;
    power_on(0);
    results();
  end
endmodule : tb
